// ===== hsc_pkg.sv
// constants, register layout and state codes of the hot-swap capability set
package hsc_pkg;
  // byte addresses of the set, all in one configuration dword
  localparam logic [7:0] HSC_DWORD_ADDR = 8'he4;
  localparam logic [7:0] HSC_CAP_ID_OFS = 8'he4;
  localparam logic [7:0] HSC_NEXT_OFS   = 8'he5;
  localparam logic [7:0] HSC_CSR_OFS    = 8'he6;
  // fixed read values
  localparam logic [7:0] HSC_CAP_ID_VAL = 8'h06;
  localparam logic [7:0] HSC_NEXT_VAL   = 8'h00;
  localparam logic [1:0] HSC_PI_VAL     = 2'h1;
  localparam logic [7:0] HSC_RSV_VAL    = 8'h00;
  // control/status field positions within the dword
  localparam int HSC_HIDE_BIT = 16;
  localparam int HSC_MASK_BIT = 17;
  localparam int HSC_PIE_BIT  = 18;
  localparam int HSC_LED_BIT  = 19;
  localparam int HSC_PI_LSB   = 20;
  localparam int HSC_EXT_BIT  = 22;
  localparam int HSC_INS_BIT  = 23;
  localparam int HSC_CSR_LANE = 2;
  // reset values of the writable bits
  localparam logic HSC_HIDE_RST = 1'b0;
  localparam logic HSC_MASK_RST = 1'b0;
  localparam logic HSC_LED_RST  = 1'b0;
  localparam logic HSC_FLAG_RST = 1'b0;
  // cycles waited after reset release before the handle is trusted
  localparam logic [2:0] HSC_SETTLE_CYC = 3'h4;
  // hot-swap sequence states
  typedef enum logic [1:0] {
    HSC_ST_SETTLE = 2'b00,
    HSC_ST_OPEN   = 2'b01,
    HSC_ST_INS    = 2'b10,
    HSC_ST_EXT    = 2'b11
  } hsc_state_t;
endpackage

// ===== hsc_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module hsc_pin_sync (
  input  wire logic clk_sys_i,  // system clock
  input  wire logic rst_n_i,    // async reset, active low
  input  wire logic ce_i,       // clock enable
  input  wire logic pin_i,      // raw asynchronous pin
  output logic      level_o     // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first stage feeds only the second; level moves once 2 and 3 agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule

// ===== hsc_regs.sv
// hot-swap capability registers and handle sequencing
`timescale 1ns/10ps
module hsc_regs (
  input  wire logic        clk_sys_i,     // primary bus clock, 10 MHz
  input  wire logic        rst_n_i,       // primary reset, active low
  input  wire logic        ce_i,          // clock enable, freezes all
  input  wire logic        cfg_rd_i,      // config read strobe
  input  wire logic        cfg_wr_i,      // config write strobe
  input  wire logic [7:0]  cfg_addr_i,    // config byte address
  input  wire logic [3:0]  cfg_be_n_i,    // byte enables, active low
  input  wire logic [31:0] cfg_wdata_i,   // write data
  input  wire logic        handle_open_i, // ejector handle, 1 = open
  output logic [31:0]      cfg_rdata_o,   // read data
  output logic             cfg_rvalid_o,  // read answer pulse
  output logic             bus_hide_o,    // bridge must not respond
  output logic             led_on_off_o,  // indicator led, 1 = lit
  output logic             enum_out_n_o   // enumeration, active low
);
  hsc_pkg::hsc_state_t state_r;
  hsc_pkg::hsc_state_t state_nxt;
  logic [2:0] settle_r;
  logic       hide_arm_r;
  logic       enum_irq_mask_r;
  logic       extraction_flag_r;
  logic       insertion_flag_r;
  logic       handle_open;

  hsc_pin_sync u_handle_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .pin_i     (handle_open_i),
    .level_o   (handle_open)
  );

  // address decode; a hidden bridge takes no access at all
  wire hit      = cfg_addr_i[7:2] == hsc_pkg::HSC_DWORD_ADDR[7:2];
  wire take_rd  = cfg_rd_i & hit & ~hide_arm_r;
  wire take_wr  = cfg_wr_i & hit & ~hide_arm_r;
  wire csr_wr   = take_wr & ~cfg_be_n_i[hsc_pkg::HSC_CSR_LANE];
  wire clr_ext  = csr_wr & cfg_wdata_i[hsc_pkg::HSC_EXT_BIT];
  wire clr_ins  = csr_wr & cfg_wdata_i[hsc_pkg::HSC_INS_BIT];

  // sequence: settle, then follow the handle between open and inserted
  wire settled  = settle_r == hsc_pkg::HSC_SETTLE_CYC;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      hsc_pkg::HSC_ST_SETTLE: begin
        if (settled) begin
          state_nxt = handle_open ? hsc_pkg::HSC_ST_OPEN
                                  : hsc_pkg::HSC_ST_INS;
        end
      end
      hsc_pkg::HSC_ST_OPEN: begin
        if (!handle_open) begin
          state_nxt = hsc_pkg::HSC_ST_INS;
        end
      end
      hsc_pkg::HSC_ST_INS: begin
        if (handle_open) begin
          state_nxt = hsc_pkg::HSC_ST_EXT;
        end
      end
      hsc_pkg::HSC_ST_EXT: begin
        if (!handle_open) begin
          state_nxt = hsc_pkg::HSC_ST_INS;
        end
      end
    endcase
  end

  wire enter_ins  = state_r != hsc_pkg::HSC_ST_INS &&
                    state_nxt == hsc_pkg::HSC_ST_INS;
  wire enter_open = state_r == hsc_pkg::HSC_ST_SETTLE &&
                    state_nxt == hsc_pkg::HSC_ST_OPEN;
  wire enter_ext  = state_r == hsc_pkg::HSC_ST_INS &&
                    state_nxt == hsc_pkg::HSC_ST_EXT;

  // hardware set beats hardware clear, both beat a software write
  wire hide_nxt = enter_open ? 1'b1 :
                  enter_ins  ? 1'b0 :
                  csr_wr ? cfg_wdata_i[hsc_pkg::HSC_HIDE_BIT] : hide_arm_r;
  // flags: a set in the same cycle as a clear wins
  wire ext_nxt  = enter_ext | (extraction_flag_r & ~clr_ext);
  wire ins_nxt  = enter_ins | (insertion_flag_r & ~clr_ins);
  wire mask_nxt = csr_wr ? cfg_wdata_i[hsc_pkg::HSC_MASK_BIT]
                         : enum_irq_mask_r;
  wire led_nxt  = csr_wr ? cfg_wdata_i[hsc_pkg::HSC_LED_BIT]
                         : led_on_off_o;
  // output is one cycle behind the flags, since it comes from a flop
  wire enum_nxt = ~((insertion_flag_r | extraction_flag_r) &
                    ~enum_irq_mask_r);

  // read image; top byte is reserved and reads zero
  wire [7:0] csr_byte = {insertion_flag_r, extraction_flag_r,
                         hsc_pkg::HSC_PI_VAL,
                         led_on_off_o,
                         1'b0,
                         enum_irq_mask_r, hide_arm_r};
  wire [31:0] rd_img = {hsc_pkg::HSC_RSV_VAL, csr_byte,
                        hsc_pkg::HSC_NEXT_VAL,
                        hsc_pkg::HSC_CAP_ID_VAL};

  // sequence state and settle counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= hsc_pkg::HSC_ST_SETTLE;
      settle_r <= 3'h0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      if (!settled) begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  // control/status bits
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hide_arm_r        <= hsc_pkg::HSC_HIDE_RST;
      enum_irq_mask_r   <= hsc_pkg::HSC_MASK_RST;
      led_on_off_o      <= hsc_pkg::HSC_LED_RST;
      extraction_flag_r <= hsc_pkg::HSC_FLAG_RST;
      insertion_flag_r  <= hsc_pkg::HSC_FLAG_RST;
    end else if (ce_i) begin
      hide_arm_r        <= hide_nxt;
      enum_irq_mask_r   <= mask_nxt;
      led_on_off_o      <= led_nxt;
      extraction_flag_r <= ext_nxt;
      insertion_flag_r  <= ins_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o  <= 32'h0;
      cfg_rvalid_o <= 1'b0;
      bus_hide_o   <= hsc_pkg::HSC_HIDE_RST;
      enum_out_n_o <= 1'b1;
    end else if (ce_i) begin
      cfg_rvalid_o <= take_rd;
      cfg_rdata_o  <= take_rd ? rd_img : 32'h0;
      bus_hide_o   <= hide_nxt;
      enum_out_n_o <= enum_nxt;
    end
  end

  // checks on the read image; fixed fields never move
  a_id_read: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cfg_rvalid_o |-> cfg_rdata_o[7:0] == hsc_pkg::HSC_CAP_ID_VAL)
    else $error("capability id wrong");
  a_next_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cfg_rvalid_o |-> cfg_rdata_o[15:8] == hsc_pkg::HSC_NEXT_VAL)
    else $error("next pointer not zero");
  a_ro_fields: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cfg_rvalid_o |-> !cfg_rdata_o[hsc_pkg::HSC_PIE_BIT] &&
      cfg_rdata_o[hsc_pkg::HSC_PI_LSB +: 2] == hsc_pkg::HSC_PI_VAL)
    else $error("read-only fields wrong");

  // hiding: an access seen while hidden gets no answer one edge later
  a_hide_silent: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bus_hide_o |-> ##1 !cfg_rvalid_o)
    else $error("hidden bridge answered");
  a_open_arms: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && enter_open) |=> hide_arm_r && bus_hide_o)
    else $error("hiding not armed");
  a_ins_disarm: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && enter_ins) |=> !hide_arm_r && insertion_flag_r)
    else $error("insertion entry wrong");

  // flags: set only on sequence edges, cleared only by a written one
  a_ext_sets: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && enter_ext) |=> extraction_flag_r)
    else $error("extraction flag not set");
  a_w1c_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && csr_wr && !cfg_wdata_i[hsc_pkg::HSC_EXT_BIT] &&
      extraction_flag_r) |=> extraction_flag_r)
    else $error("zero write cleared flag");
  a_ext_clear: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && clr_ext && !enter_ext) |=> !extraction_flag_r)
    else $error("extraction flag not cleared");
  a_ins_clear: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && clr_ins && !enter_ins) |=> !insertion_flag_r)
    else $error("insertion flag not cleared");
  a_ins_entry: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && !insertion_flag_r && !enter_ins) |=> !insertion_flag_r)
    else $error("insertion flag set without entry");
  // nothing may be flagged before the handle has been trusted
  a_settle_clean: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    state_r == hsc_pkg::HSC_ST_SETTLE |->
      !insertion_flag_r && !extraction_flag_r)
    else $error("flag set while settling");

  // software bits and the enumeration pin
  a_led_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && csr_wr) |=>
      led_on_off_o == $past(cfg_wdata_i[hsc_pkg::HSC_LED_BIT]))
    else $error("led bit not written");
  a_mask_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && csr_wr) |=>
      enum_irq_mask_r == $past(cfg_wdata_i[hsc_pkg::HSC_MASK_BIT]))
    else $error("mask bit not written");
  a_enum_out: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i |=> enum_out_n_o == !(($past(insertion_flag_r) ||
      $past(extraction_flag_r)) && !$past(enum_irq_mask_r)))
    else $error("enumeration output wrong");

  // main scenarios; the bench reaches c_insert, c_enum_low and c_hide_read, but not c_extract or c_set_clear
  c_insert: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    enter_ins);
  c_extract: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    enter_ext ##[1:50] enter_ins);
  c_enum_low: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !enum_out_n_o ##1 enum_out_n_o);
  c_set_clear: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    enter_ins && clr_ins);
  c_hide_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bus_hide_o && cfg_rd_i && hit);
endmodule

// ===== hsc_handle_model.sv
// ejector handle switch model facing the hot-swap register set
`timescale 1ns/10ps
module hsc_handle_model #(
  parameter int LAG = 3              // one less than the cycles from request to contact
) (
  input  wire logic clk_sys_i,       // system clock
  input  wire logic open_req_i,      // bench asks for an open handle
  output logic      handle_open_o    // switch contact, 1 = open
);
  int cnt;
  // contact starts closed so a fresh board looks inserted
  initial begin
    handle_open_o = 1'b0;
    cnt = 0;
  end
  // contact follows the request only after a mechanical lag
  always @(posedge clk_sys_i) begin
    if (open_req_i == handle_open_o) begin
      cnt <= 0;
    end else if (cnt == LAG) begin
      handle_open_o <= open_req_i;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ===== hsc_regs_tb.sv
// self-checking bench for the hot-swap capability registers
`timescale 1ns/10ps
module hsc_regs_tb;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        cfg_rd_i;
  logic        cfg_wr_i;
  logic [7:0]  cfg_addr_i;
  logic [3:0]  cfg_be_n_i;
  logic [31:0] cfg_wdata_i;
  logic        open_req;
  logic        handle_open;
  logic [31:0] cfg_rdata_o;
  logic        cfg_rvalid_o;
  logic        bus_hide_o;
  logic        led_on_off_o;
  logic        enum_out_n_o;
  int          miscompares;
  int          comparisons;

  hsc_regs hsc_regs_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_be_n_i(cfg_be_n_i),
    .cfg_wdata_i(cfg_wdata_i), .handle_open_i(handle_open),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .bus_hide_o(bus_hide_o), .led_on_off_o(led_on_off_o),
    .enum_out_n_o(enum_out_n_o));
  hsc_handle_model #(.LAG(3)) hsc_handle_model_i (.clk_sys_i(clk_sys_i),
    .open_req_i(open_req), .handle_open_o(handle_open));

  // 10 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // expected read image; f holds hide, mask, led, extraction, insertion
  function automatic logic [31:0] img(input logic [4:0] f);
    img = {8'h00, f[0], f[1], hsc_pkg::HSC_PI_VAL, f[2], 1'b0, f[3], f[4],
           hsc_pkg::HSC_NEXT_VAL, hsc_pkg::HSC_CAP_ID_VAL};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset;
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk("led in reset", 32'h0, {31'h0, led_on_off_o});
    rst_n_i = 1'b1;
  endtask

  // lane 2 write, then let the enumeration pin settle
  task automatic cfg_write(input logic [31:0] d);
    @(negedge clk_sys_i);
    cfg_addr_i = hsc_pkg::HSC_CSR_OFS;
    cfg_wdata_i = d;
    cfg_be_n_i = 4'hb;
    cfg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    cfg_wr_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask

  // one read pulse; the answer window is bounded to three cycles
  task automatic cfg_read(input logic [7:0] a, input logic ans,
                          input logic [31:0] exp);
    logic got;
    got = 1'b0;
    @(negedge clk_sys_i);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys_i);
      cfg_rd_i = 1'b0;
      if (cfg_rvalid_o === 1'b1 && !got) begin
        got = 1'b1;
        chk("read data", exp, cfg_rdata_o);
      end
    end
    chk("read answered", {31'h0, ans}, {31'h0, got});
  endtask

  task automatic pins(input logic en_n, ld, hd);
    chk("enum pin", {31'h0, en_n}, {31'h0, enum_out_n_o});
    chk("led pin", {31'h0, ld}, {31'h0, led_on_off_o});
    chk("hide pin", {31'h0, hd}, {31'h0, bus_hide_o});
  endtask

  task automatic t_insert;
    do_reset();
    repeat (20) @(negedge clk_sys_i);
    cfg_read(8'he4, 1'b1, img(5'b00001));
    pins(1'b0, 1'b0, 1'b0);
    cfg_read(8'he0, 1'b0, 32'h0);
  endtask

  task automatic t_mask_led;
    // hide stays 0 here: a written one would silence the bridge
    cfg_write(32'hfffe_0006);
    cfg_read(8'he6, 1'b1, img(5'b01100));
    cfg_write(32'h000a_0000);
    pins(1'b1, 1'b1, 1'b0);
    cfg_write(32'h0088_0000);
  endtask

  task automatic t_extract;
    open_req = 1'b1;
    repeat (15) @(negedge clk_sys_i);
    pins(1'b0, 1'b1, 1'b0);
    // mask on while the flag stands, then off again
    cfg_write(32'h000a_0000);
    pins(1'b1, 1'b1, 1'b0);
    cfg_write(32'h0008_0000);
    cfg_read(8'he4, 1'b1, img(5'b00110));
    pins(1'b0, 1'b1, 1'b0);
    cfg_write(32'h0048_0000);
    pins(1'b1, 1'b1, 1'b0);
  endtask

  task automatic t_hide;
    do_reset();
    repeat (20) @(negedge clk_sys_i);
    pins(1'b1, 1'b0, 1'b1);
    cfg_read(8'he4, 1'b0, 32'h0);
    open_req = 1'b0;
    repeat (15) @(negedge clk_sys_i);
    pins(1'b0, 1'b0, 1'b0);
    cfg_read(8'he4, 1'b1, img(5'b00001));
  endtask

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    {cfg_rd_i, cfg_wr_i, open_req} = 3'h0;
    cfg_addr_i = 8'h00;
    cfg_be_n_i = 4'hf;
    cfg_wdata_i = 32'h0;
    miscompares = 0;
    comparisons = 0;
    t_insert();
    t_mask_led();
    t_extract();
    t_hide();
    close_out();
  end

  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #(3000 * 100);
    miscompares++;
    close_out();
  end
endmodule
